// file: hw/conv_exc_pkg.sv
// Constants and types shared by the packed-conversion exception checker.
package conv_exc_pkg;

  // Register offsets on the APB port.
  localparam logic [11:0] OFS_CTRL_REG_ZERO  = 12'h000;
  localparam logic [11:0] OFS_CTRL_REG_FOUR  = 12'h004;
  localparam logic [11:0] OFS_FEATURE        = 12'h008;
  localparam logic [11:0] OFS_LAST_FAULT     = 12'h00C;
  localparam logic [11:0] OFS_FAULT_COUNT    = 12'h010;

  // Field positions.
  localparam int unsigned FPU_EMULATION_BIT_POS   = 2;
  localparam int unsigned TASK_SWITCHED_BIT_POS   = 3;
  localparam int unsigned ALIGN_MASK_BIT_POS      = 18;
  localparam int unsigned OS_SAVE_RESTORE_POS     = 9;
  localparam int unsigned OS_VECTOR_EXC_POS       = 10;
  localparam int unsigned LAST_VECTOR_LSB         = 8;

  // Reset values.
  localparam logic [31:0] CTRL_REG_ZERO_RST = 32'h0000_0000;
  localparam logic [31:0] CTRL_REG_FOUR_RST = 32'h0000_0000;
  localparam logic [2:0]  FEATURE_RST       = 3'h7;
  localparam logic [15:0] FAULT_COUNT_RST   = 16'h0000;

  // Operand geometry.
  localparam int unsigned VA_BITS_DEFAULT   = 48;
  localparam logic [16:0] LAST_BYTE_WIDE    = 17'h0000F;
  localparam logic [16:0] LAST_BYTE_NARROW  = 17'h00007;
  localparam logic [16:0] REAL_ADDR_LIMIT   = 17'h0FFFF;
  localparam logic [3:0]  ALIGN_WIDE_MASK   = 4'hF;
  localparam logic [3:0]  ALIGN_NARROW_MASK = 4'h7;
  localparam logic [1:0]  USER_PRIV_LEVEL   = 2'h3;

  // Fault vectors.
  localparam logic [7:0] VEC_INVALID_OPCODE   = 8'h06;
  localparam logic [7:0] VEC_DEVICE_UNAVAIL   = 8'h07;
  localparam logic [7:0] VEC_STACK            = 8'h0C;
  localparam logic [7:0] VEC_GENERAL_PROT     = 8'h0D;
  localparam logic [7:0] VEC_PAGE_TRANSLATION = 8'h0E;
  localparam logic [7:0] VEC_FPU_ERROR        = 8'h10;
  localparam logic [7:0] VEC_ALIGNMENT_CHECK  = 8'h11;
  localparam logic [7:0] VEC_VECTOR_FP        = 8'h13;
  localparam logic [7:0] VEC_NONE             = 8'h00;
  localparam logic [31:0] ERR_CODE_ZERO       = 32'h0000_0000;

  typedef enum logic [1:0] {
    MODE_REAL,
    MODE_V86,
    MODE_PROT,
    MODE_LONG
  } op_mode_t;

  typedef enum logic [1:0] {
    CLS_DBL_TO_INT,
    CLS_SINGLE,
    CLS_INT_TO_DBL
  } conv_class_t;

  typedef enum logic [3:0] {
    FLT_NONE,
    FLT_INVALID_OPCODE,
    FLT_DEVICE_UNAVAILABLE,
    FLT_FPU_ERROR,
    FLT_STACK,
    FLT_GENERAL_PROTECTION,
    FLT_PAGE_TRANSLATION,
    FLT_ALIGNMENT_CHECK,
    FLT_VECTOR_FP
  } fault_t;

endpackage

// file: hw/operand_addr_check.sv
// Segment, canonical, real-mode range and alignment checks on a memory operand.
`timescale 1ns/10ps
module operand_addr_check #(
  parameter int unsigned VA_BITS = conv_exc_pkg::VA_BITS_DEFAULT
) (
  // Operand
  input  wire logic [63:0]           addr,
  input  wire conv_exc_pkg::op_mode_t mode,
  input  wire logic                  wide,
  input  wire logic                  stack_ref,
  input  wire logic                  seg_illegal,
  // Results
  output logic                       stack_fault,
  output logic                       prot_fault,
  output logic                       unaligned_wide,
  output logic                       unaligned_narrow
);

  logic        non_canonical;
  logic [16:0] last_byte;
  logic        out_of_range;
  logic        prot;
  logic        long_mode;
  logic        low_modes;

  always_comb begin
    non_canonical = !((&addr[63:VA_BITS-1]) || !(|addr[63:VA_BITS-1]));
    last_byte = {1'b0, addr[15:0]} + (wide ? conv_exc_pkg::LAST_BYTE_WIDE : conv_exc_pkg::LAST_BYTE_NARROW);
    // Real and virtual-mode offsets are 16 bits; upper bits set also fall outside the range.
    out_of_range = (|addr[63:16]) || (last_byte > conv_exc_pkg::REAL_ADDR_LIMIT);
    prot = (mode == conv_exc_pkg::MODE_PROT);
    long_mode = (mode == conv_exc_pkg::MODE_LONG);
    low_modes = (mode == conv_exc_pkg::MODE_REAL) || (mode == conv_exc_pkg::MODE_V86);
    stack_fault = (prot && stack_ref && seg_illegal)
                || (long_mode && stack_ref && non_canonical);
    prot_fault = (prot && !stack_ref && seg_illegal)
             || (long_mode && !stack_ref && non_canonical)
             || (low_modes && out_of_range);
    unaligned_wide = |(addr[3:0] & conv_exc_pkg::ALIGN_WIDE_MASK);
    unaligned_narrow = |(addr[3:0] & conv_exc_pkg::ALIGN_NARROW_MASK);
  end

endmodule

// file: hw/conv_exc_check.sv
// Exception selection for packed conversions, with an APB control and status port.
//
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/10ps
module conv_exc_check #(
  parameter int unsigned VA_BITS = conv_exc_pkg::VA_BITS_DEFAULT
) (
  // Clock and reset
  input  wire logic                     CLK_SYS,
  input  wire logic                     NRST,
  // APB slave
  input  wire logic                     PSEL,
  input  wire logic                     PENABLE,
  input  wire logic                     PWRITE,
  input  wire logic [11:0]              PADDR,
  input  wire logic [31:0]              PWDATA,
  output logic      [31:0]              PRDATA,
  output logic                          PREADY,
  output logic                          PSLVERR,
  // Instruction check request
  input  wire logic                     REQ_VALID,
  input  wire conv_exc_pkg::conv_class_t REQ_CLASS,
  input  wire conv_exc_pkg::op_mode_t   REQ_MODE,
  input  wire logic                     REQ_LOCK,
  input  wire logic                     REQ_PRIOR_EVENT,
  input  wire logic                     REQ_FPU_PENDING,
  input  wire logic                     REQ_SIMD_UNMASKED,
  input  wire logic                     REQ_MEM,
  input  wire logic [63:0]              REQ_ADDR,
  input  wire logic                     REQ_STACK_REF,
  input  wire logic                     REQ_SEG_ILLEGAL,
  input  wire logic                     REQ_PAGE_FAIL,
  input  wire logic [31:0]              REQ_PAGE_CODE,
  input  wire logic                     REQ_ALIGN_FLAG,
  input  wire logic [1:0]               REQ_PRIV_LEVEL,
  // Fault report
  output logic                          RSP_VALID,
  output conv_exc_pkg::fault_t          RSP_FAULT,
  output logic      [7:0]               RSP_VECTOR,
  output logic                          RSP_ERR_VALID,
  output logic      [31:0]              RSP_ERR_CODE
);

  // Vector number for each fault kind.
  function automatic logic [7:0] fault_vector(input conv_exc_pkg::fault_t f);
    logic [7:0] v;
    v = conv_exc_pkg::VEC_NONE;
    case (f)
      conv_exc_pkg::FLT_INVALID_OPCODE:     v = conv_exc_pkg::VEC_INVALID_OPCODE;
      conv_exc_pkg::FLT_DEVICE_UNAVAILABLE: v = conv_exc_pkg::VEC_DEVICE_UNAVAIL;
      conv_exc_pkg::FLT_FPU_ERROR:          v = conv_exc_pkg::VEC_FPU_ERROR;
      conv_exc_pkg::FLT_STACK:              v = conv_exc_pkg::VEC_STACK;
      conv_exc_pkg::FLT_GENERAL_PROTECTION: v = conv_exc_pkg::VEC_GENERAL_PROT;
      conv_exc_pkg::FLT_PAGE_TRANSLATION:   v = conv_exc_pkg::VEC_PAGE_TRANSLATION;
      conv_exc_pkg::FLT_ALIGNMENT_CHECK:    v = conv_exc_pkg::VEC_ALIGNMENT_CHECK;
      conv_exc_pkg::FLT_VECTOR_FP:          v = conv_exc_pkg::VEC_VECTOR_FP;
      default:                              v = conv_exc_pkg::VEC_NONE;
    endcase
    return v;
  endfunction

  // Faults that push an error code onto the handler stack.
  function automatic logic fault_has_code(input conv_exc_pkg::fault_t f);
    return (f == conv_exc_pkg::FLT_STACK) || (f == conv_exc_pkg::FLT_GENERAL_PROTECTION)
        || (f == conv_exc_pkg::FLT_PAGE_TRANSLATION) || (f == conv_exc_pkg::FLT_ALIGNMENT_CHECK);
  endfunction

  // Register selected by an APB address.
  typedef enum logic [2:0] {
    SEL_CTRL_ZERO,
    SEL_CTRL_FOUR,
    SEL_FEATURE,
    SEL_LAST_FAULT,
    SEL_FAULT_COUNT,
    SEL_NONE
  } reg_sel_t;

  // One decoder serves the error flag, the read mux and the write strobes, so they cannot disagree.
  function automatic reg_sel_t reg_select(input logic [11:0] a);
    reg_sel_t s;
    s = SEL_NONE;
    case (a)
      conv_exc_pkg::OFS_CTRL_REG_ZERO: s = SEL_CTRL_ZERO;
      conv_exc_pkg::OFS_CTRL_REG_FOUR: s = SEL_CTRL_FOUR;
      conv_exc_pkg::OFS_FEATURE:       s = SEL_FEATURE;
      conv_exc_pkg::OFS_LAST_FAULT:    s = SEL_LAST_FAULT;
      conv_exc_pkg::OFS_FAULT_COUNT:   s = SEL_FAULT_COUNT;
      default:                         s = SEL_NONE;
    endcase
    return s;
  endfunction

  // Register state.
  logic [31:0]          ctrl_zero_q;
  logic [31:0]          ctrl_zero_d;
  logic [31:0]          ctrl_four_q;
  logic [31:0]          ctrl_four_d;
  logic [2:0]           feature_q;
  logic [2:0]           feature_d;
  conv_exc_pkg::fault_t last_fault_q;
  conv_exc_pkg::fault_t last_fault_d;
  logic [15:0]          fault_count_q;
  logic [15:0]          fault_count_d;
  logic [31:0]          prdata_q;
  logic [31:0]          prdata_d;
  logic                 pready_q;
  logic                 pready_d;
  logic                 pslverr_q;
  logic                 pslverr_d;

  // Report state.
  logic                 rsp_valid_q;
  logic                 rsp_valid_d;
  conv_exc_pkg::fault_t rsp_fault_q;
  conv_exc_pkg::fault_t rsp_fault_d;
  logic [7:0]           rsp_vector_q;
  logic [7:0]           rsp_vector_d;
  logic                 rsp_err_valid_q;
  logic                 rsp_err_valid_d;
  logic [31:0]          rsp_err_code_q;
  logic [31:0]          rsp_err_code_d;

  // Operand check results.
  logic                 mem_stack_fault;
  logic                 mem_prot_fault;
  logic                 mem_unaligned_wide;
  logic                 mem_unaligned_narrow;

  // Decoded conditions.
  logic                 wide_operand;
  logic                 opcode_bad;
  logic                 fpu_check;
  logic                 align_fault;
  logic                 page_fault;
  logic                 simd_capable;
  conv_exc_pkg::fault_t chosen;
  logic                 apb_access;
  logic                 apb_write;
  logic                 addr_mapped;
  reg_sel_t             reg_sel;

  assign wide_operand = (REQ_CLASS == conv_exc_pkg::CLS_DBL_TO_INT);

  operand_addr_check #(
    .VA_BITS (VA_BITS)
  ) u_addr_check (
    .addr             (REQ_ADDR),
    .mode             (REQ_MODE),
    .wide             (wide_operand),
    .stack_ref        (REQ_STACK_REF),
    .seg_illegal      (REQ_SEG_ILLEGAL),
    .stack_fault      (mem_stack_fault),
    .prot_fault       (mem_prot_fault),
    .unaligned_wide   (mem_unaligned_wide),
    .unaligned_narrow (mem_unaligned_narrow)
  );

  // Fault selection. The chain is a strict priority so only one fault leaves per instruction.
  always_comb begin
    opcode_bad = ctrl_zero_q[conv_exc_pkg::FPU_EMULATION_BIT_POS]
              || !ctrl_four_q[conv_exc_pkg::OS_SAVE_RESTORE_POS]
              || REQ_LOCK
              || !feature_q[REQ_CLASS];
    // The integer-to-double memory form reads no FPU state, so a pending FPU error waits.
    fpu_check = REQ_FPU_PENDING && !((REQ_CLASS == conv_exc_pkg::CLS_INT_TO_DBL) && REQ_MEM);
    align_fault = REQ_MEM && (REQ_CLASS != conv_exc_pkg::CLS_DBL_TO_INT)
               && (REQ_MODE != conv_exc_pkg::MODE_REAL)
               && ctrl_zero_q[conv_exc_pkg::ALIGN_MASK_BIT_POS] && REQ_ALIGN_FLAG
               && (REQ_PRIV_LEVEL == conv_exc_pkg::USER_PRIV_LEVEL)
               && mem_unaligned_narrow;
    page_fault = REQ_MEM && REQ_PAGE_FAIL && (REQ_MODE != conv_exc_pkg::MODE_REAL);
    simd_capable = (REQ_CLASS != conv_exc_pkg::CLS_INT_TO_DBL);
    chosen = conv_exc_pkg::FLT_NONE;
    if (REQ_PRIOR_EVENT) begin
      // An earlier trap, interrupt, fetch or decode fault is handled first and this one is dropped.
      chosen = conv_exc_pkg::FLT_NONE;
    end else if (opcode_bad) begin
      chosen = conv_exc_pkg::FLT_INVALID_OPCODE;
    end else if (ctrl_zero_q[conv_exc_pkg::TASK_SWITCHED_BIT_POS]) begin
      chosen = conv_exc_pkg::FLT_DEVICE_UNAVAILABLE;
    end else if (fpu_check) begin
      chosen = conv_exc_pkg::FLT_FPU_ERROR;
    end else if (REQ_MEM && mem_stack_fault) begin
      chosen = conv_exc_pkg::FLT_STACK;
    end else if (REQ_MEM && wide_operand && mem_unaligned_wide) begin
      chosen = conv_exc_pkg::FLT_GENERAL_PROTECTION;
    end else if (REQ_MEM && mem_prot_fault) begin
      chosen = conv_exc_pkg::FLT_GENERAL_PROTECTION;
    end else if (page_fault) begin
      chosen = conv_exc_pkg::FLT_PAGE_TRANSLATION;
    end else if (align_fault) begin
      chosen = conv_exc_pkg::FLT_ALIGNMENT_CHECK;
    end else if (simd_capable && REQ_SIMD_UNMASKED) begin
      if (ctrl_four_q[conv_exc_pkg::OS_VECTOR_EXC_POS]) begin
        chosen = conv_exc_pkg::FLT_VECTOR_FP;
      end else begin
        chosen = conv_exc_pkg::FLT_INVALID_OPCODE;
      end
    end
  end

  // Report path: one registered answer for every request.
  // Fields other than valid hold their last answer, so a consumer may read them late.
  always_comb begin
    rsp_valid_d = REQ_VALID;
    rsp_fault_d = rsp_fault_q;
    rsp_vector_d = rsp_vector_q;
    rsp_err_valid_d = rsp_err_valid_q;
    rsp_err_code_d = rsp_err_code_q;
    if (REQ_VALID) begin
      rsp_fault_d = chosen;
      rsp_vector_d = fault_vector(chosen);
      rsp_err_valid_d = fault_has_code(chosen);
      rsp_err_code_d = (chosen == conv_exc_pkg::FLT_PAGE_TRANSLATION) ? REQ_PAGE_CODE
                     : conv_exc_pkg::ERR_CODE_ZERO;
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      rsp_valid_q <= 1'b0;
      rsp_fault_q <= conv_exc_pkg::FLT_NONE;
      rsp_vector_q <= conv_exc_pkg::VEC_NONE;
      rsp_err_valid_q <= 1'b0;
      rsp_err_code_q <= conv_exc_pkg::ERR_CODE_ZERO;
    end else begin
      rsp_valid_q <= rsp_valid_d;
      rsp_fault_q <= rsp_fault_d;
      rsp_vector_q <= rsp_vector_d;
      rsp_err_valid_q <= rsp_err_valid_d;
      rsp_err_code_q <= rsp_err_code_d;
    end
  end

  // APB slave with one wait state: ready rises in the second access cycle.
  always_comb begin
    apb_access = PSEL && PENABLE;
    apb_write = apb_access && pready_q && PWRITE;
    reg_sel = reg_select(PADDR);
    addr_mapped = (reg_sel != SEL_NONE);
    pready_d = apb_access && !pready_q;
    pslverr_d = apb_access && !pready_q && !addr_mapped;
    prdata_d = 32'h0000_0000;
    // Read data is latched in the first access cycle so that it stands while ready is high.
    if (apb_access && !pready_q && !PWRITE) begin
      case (reg_sel)
        SEL_CTRL_ZERO:   prdata_d = ctrl_zero_q;
        SEL_CTRL_FOUR:   prdata_d = ctrl_four_q;
        SEL_FEATURE:     prdata_d = {29'h0000_0000, feature_q};
        SEL_LAST_FAULT:  prdata_d = {16'h0000, fault_vector(last_fault_q), 4'h0, last_fault_q};
        SEL_FAULT_COUNT: prdata_d = {16'h0000, fault_count_q};
        default:         prdata_d = 32'h0000_0000;
      endcase
    end
    ctrl_zero_d = ctrl_zero_q;
    ctrl_four_d = ctrl_four_q;
    feature_d = feature_q;
    if (apb_write) begin
      case (reg_sel)
        SEL_CTRL_ZERO: ctrl_zero_d = PWDATA;
        SEL_CTRL_FOUR: ctrl_four_d = PWDATA;
        SEL_FEATURE:   feature_d = PWDATA[2:0];
        default:       feature_d = feature_q;
      endcase
    end
    // A fault counted in the same cycle as a write to the counter is kept: the write clears and the count restarts at one.
    last_fault_d = last_fault_q;
    fault_count_d = fault_count_q;
    if (apb_write && (reg_sel == SEL_FAULT_COUNT)) begin
      fault_count_d = conv_exc_pkg::FAULT_COUNT_RST;
    end
    if (REQ_VALID && (chosen != conv_exc_pkg::FLT_NONE)) begin
      last_fault_d = chosen;
      fault_count_d = fault_count_d + 16'h0001;
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      ctrl_zero_q <= conv_exc_pkg::CTRL_REG_ZERO_RST;
      ctrl_four_q <= conv_exc_pkg::CTRL_REG_FOUR_RST;
      feature_q <= conv_exc_pkg::FEATURE_RST;
      last_fault_q <= conv_exc_pkg::FLT_NONE;
      fault_count_q <= conv_exc_pkg::FAULT_COUNT_RST;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      ctrl_zero_q <= ctrl_zero_d;
      ctrl_four_q <= ctrl_four_d;
      feature_q <= feature_d;
      last_fault_q <= last_fault_d;
      fault_count_q <= fault_count_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // Every port comes straight from a flip-flop, so no decode glitch reaches the pins.
  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign RSP_VALID = rsp_valid_q;
  assign RSP_FAULT = rsp_fault_q;
  assign RSP_VECTOR = rsp_vector_q;
  assign RSP_ERR_VALID = rsp_err_valid_q;
  assign RSP_ERR_CODE = rsp_err_code_q;

endmodule

// file: tb/conv_exc_assertions.sv
// Port-level assertions for the packed-conversion exception checker.
`timescale 1ns/10ps
module conv_exc_assertions #(
  parameter int unsigned VA_BITS = conv_exc_pkg::VA_BITS_DEFAULT
) (
  // Clock and reset
  input wire logic                       CLK_SYS,
  input wire logic                       NRST,
  // Request
  input wire logic                       REQ_VALID,
  input wire conv_exc_pkg::conv_class_t  REQ_CLASS,
  input wire conv_exc_pkg::op_mode_t     REQ_MODE,
  input wire logic                       REQ_LOCK,
  input wire logic                       REQ_PRIOR_EVENT,
  input wire logic                       REQ_MEM,
  input wire logic [31:0]                REQ_PAGE_CODE,
  // Report
  input wire logic                       RSP_VALID,
  input wire conv_exc_pkg::fault_t       RSP_FAULT,
  input wire logic [7:0]                 RSP_VECTOR,
  input wire logic                       RSP_ERR_VALID,
  input wire logic [31:0]                RSP_ERR_CODE
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);

  rsp_timing_a: assert property (REQ_VALID |=> RSP_VALID) else $error("answer missing");
  rsp_cause_a: assert property (RSP_VALID |-> $past(REQ_VALID)) else $error("answer without request");
  prior_quiet_a: assert property (REQ_VALID && REQ_PRIOR_EVENT |=> RSP_FAULT == conv_exc_pkg::FLT_NONE)
    else $error("fault despite earlier event");
  lock_opcode_a: assert property (REQ_VALID && REQ_LOCK && !REQ_PRIOR_EVENT |=>
    RSP_FAULT == conv_exc_pkg::FLT_INVALID_OPCODE) else $error("lock prefix not refused");
  fp_vector_a: assert property (RSP_VALID && RSP_FAULT == conv_exc_pkg::FLT_VECTOR_FP |-> RSP_VECTOR == 8'h13)
    else $error("wrong vector fp vector");
  page_code_a: assert property (REQ_VALID ##1 RSP_FAULT == conv_exc_pkg::FLT_PAGE_TRANSLATION |->
    RSP_ERR_VALID && RSP_ERR_CODE == $past(REQ_PAGE_CODE)) else $error("page error code lost");
  stack_code_a: assert property (RSP_VALID && RSP_FAULT == conv_exc_pkg::FLT_STACK |->
    RSP_ERR_VALID && RSP_ERR_CODE == 32'h0) else $error("stack fault code not zero");
  real_nopage_a: assert property (REQ_VALID && REQ_MODE == conv_exc_pkg::MODE_REAL |=>
    !(RSP_FAULT inside {conv_exc_pkg::FLT_PAGE_TRANSLATION, conv_exc_pkg::FLT_ALIGNMENT_CHECK}))
    else $error("paging or alignment fault in real mode");
  i2d_novfp_a: assert property (REQ_VALID && REQ_CLASS == conv_exc_pkg::CLS_INT_TO_DBL |=>
    RSP_FAULT != conv_exc_pkg::FLT_VECTOR_FP) else $error("vector fp fault on int to double");
  reg_nomem_a: assert property (REQ_VALID && !REQ_MEM |=> !(RSP_FAULT inside {conv_exc_pkg::FLT_STACK,
    conv_exc_pkg::FLT_GENERAL_PROTECTION, conv_exc_pkg::FLT_PAGE_TRANSLATION, conv_exc_pkg::FLT_ALIGNMENT_CHECK}))
    else $error("memory fault on register operand");
endmodule

bind conv_exc_check conv_exc_assertions #(.VA_BITS(VA_BITS)) conv_exc_assertions_i (.CLK_SYS(CLK_SYS), .NRST(NRST),
  .REQ_VALID(REQ_VALID), .REQ_CLASS(REQ_CLASS), .REQ_MODE(REQ_MODE), .REQ_LOCK(REQ_LOCK),
  .REQ_PRIOR_EVENT(REQ_PRIOR_EVENT), .REQ_MEM(REQ_MEM), .REQ_PAGE_CODE(REQ_PAGE_CODE), .RSP_VALID(RSP_VALID),
  .RSP_FAULT(RSP_FAULT), .RSP_VECTOR(RSP_VECTOR), .RSP_ERR_VALID(RSP_ERR_VALID), .RSP_ERR_CODE(RSP_ERR_CODE));

// file: tb/decode_pipe_model.sv
// Request source standing in for the core's decode and execute pipeline.
`timescale 1ns/10ps
package req_tb_pkg;
  typedef struct packed {
    conv_exc_pkg::conv_class_t cls;
    conv_exc_pkg::op_mode_t    mode;
    logic                      lock, prior, fpu, simd, mem;
    logic [63:0]               addr;
    logic                      stk, seg, pgf;
    logic [31:0]               pc;
    logic                      af;
    logic [1:0]                pl;
  } req_t;
endpackage

module decode_pipe_model (
  // Clock
  input wire logic          CLK_SYS,
  // Request towards the checker
  output logic              valid,
  output req_tb_pkg::req_t  rq
);
  initial begin
    valid = 1'b0;
    rq = '0;
  end
  task automatic issue(input req_tb_pkg::req_t r);
    @(posedge CLK_SYS);
    valid <= 1'b1;
    rq <= r;
  endtask
  // Fields are inverted once the slot closes, so the checker cannot lean on stale values.
  task automatic idle();
    @(posedge CLK_SYS);
    valid <= 1'b0;
    rq <= req_tb_pkg::req_t'(~rq);
  endtask
endmodule

// file: tb/testbench.sv
// Self-checking bench for the packed-conversion exception checker.
`timescale 1ns/10ps
module testbench;
  logic                 CLK_SYS, NRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, RSP_VALID, RSP_ERR_VALID, req_v, err;
  logic [11:0]          PADDR;
  logic [31:0]          PWDATA, PRDATA, RSP_ERR_CODE, cr0, cr4, rd;
  logic [7:0]           RSP_VECTOR;
  logic [2:0]           feat;
  conv_exc_pkg::fault_t RSP_FAULT;
  req_tb_pkg::req_t     rq, r;
  logic [44:0]          expq[$], e;
  logic [15:0]          lf;
  int                   n_errors = 0, num_checks = 0, cyc = 0, nf;

  initial CLK_SYS = 1'b0;
  always #12.5 CLK_SYS = ~CLK_SYS;

  conv_exc_check conv_exc_check_i (.CLK_SYS(CLK_SYS), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .REQ_VALID(req_v),
    .REQ_CLASS(rq.cls), .REQ_MODE(rq.mode), .REQ_LOCK(rq.lock), .REQ_PRIOR_EVENT(rq.prior), .REQ_FPU_PENDING(rq.fpu),
    .REQ_SIMD_UNMASKED(rq.simd), .REQ_MEM(rq.mem), .REQ_ADDR(rq.addr), .REQ_STACK_REF(rq.stk),
    .REQ_SEG_ILLEGAL(rq.seg), .REQ_PAGE_FAIL(rq.pgf), .REQ_PAGE_CODE(rq.pc), .REQ_ALIGN_FLAG(rq.af),
    .REQ_PRIV_LEVEL(rq.pl), .RSP_VALID(RSP_VALID), .RSP_FAULT(RSP_FAULT), .RSP_VECTOR(RSP_VECTOR),
    .RSP_ERR_VALID(RSP_ERR_VALID), .RSP_ERR_CODE(RSP_ERR_CODE));
  decode_pipe_model decode_pipe_model_i (.CLK_SYS(CLK_SYS), .valid(req_v), .rq(rq));

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    if (n_errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge CLK_SYS);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    @(posedge CLK_SYS);
    while (PREADY !== 1'b1 && k < 50) begin
      @(posedge CLK_SYS);
      k++;
    end
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    if (k >= 50) begin
      n_errors++;
      stop_test();
    end
  endtask

  function automatic req_tb_pkg::req_t rand_req();
    req_tb_pkg::req_t q;
    logic [63:0] hi [4] = '{64'h0, 64'hFFFF_8000_0000_0000, 64'h0000_8000_0000_0000, 64'h0000_0000_0001_0000};
    q = '0;
    q.cls = conv_exc_pkg::conv_class_t'($urandom_range(0, 2));
    q.mode = conv_exc_pkg::op_mode_t'($urandom_range(0, 3));
    q.lock = ($urandom_range(0, 7) == 0);
    q.prior = ($urandom_range(0, 7) == 0);
    q.fpu = ($urandom_range(0, 3) == 0);
    q.simd = 1'($urandom);
    q.mem = ($urandom_range(0, 3) != 0);
    q.addr = hi[$urandom_range(0, 3)] | 64'($urandom_range(0, 1) ? 16'hFFF0 + 16'($urandom_range(0, 15)) : 16'($urandom));
    q.stk = 1'($urandom);
    q.seg = ($urandom_range(0, 3) == 0);
    q.pgf = ($urandom_range(0, 3) == 0);
    q.pc = $urandom;
    q.af = 1'($urandom);
    q.pl = 2'($urandom);
    return q;
  endfunction

  function automatic logic [44:0] expect_of(req_tb_pkg::req_t q);
    conv_exc_pkg::fault_t f;
    logic [7:0] vtab [9] = '{8'h00, 8'h06, 8'h07, 8'h10, 8'h0C, 8'h0D, 8'h0E, 8'h11, 8'h13};
    logic canon, rng, sbad, d2i;
    canon = &q.addr[63:47] | ~|q.addr[63:47];
    rng = q.addr[63:16] == 48'h0 && {1'b0, q.addr[15:0]} + (q.cls == 0 ? 17'h0000F : 17'h00007) <= 17'h0FFFF;
    sbad = q.mode == conv_exc_pkg::MODE_PROT && q.seg || q.mode == conv_exc_pkg::MODE_LONG && !canon;
    d2i = q.cls == conv_exc_pkg::CLS_DBL_TO_INT;
    f = conv_exc_pkg::FLT_NONE;
    if (q.prior) f = conv_exc_pkg::FLT_NONE;
    else if (cr0[2] || !cr4[9] || q.lock || !feat[q.cls]) f = conv_exc_pkg::FLT_INVALID_OPCODE;
    else if (cr0[3]) f = conv_exc_pkg::FLT_DEVICE_UNAVAILABLE;
    else if (q.fpu && !(q.cls == conv_exc_pkg::CLS_INT_TO_DBL && q.mem)) f = conv_exc_pkg::FLT_FPU_ERROR;
    else if (q.mem && q.stk && sbad) f = conv_exc_pkg::FLT_STACK;
    else if (q.mem && (d2i && q.addr[3:0] != 4'h0 || !q.stk && sbad)) f = conv_exc_pkg::FLT_GENERAL_PROTECTION;
    else if (q.mem && q.mode inside {conv_exc_pkg::MODE_REAL, conv_exc_pkg::MODE_V86} && !rng)
      f = conv_exc_pkg::FLT_GENERAL_PROTECTION;
    else if (q.mem && q.mode != conv_exc_pkg::MODE_REAL && q.pgf) f = conv_exc_pkg::FLT_PAGE_TRANSLATION;
    else if (q.mem && !d2i && q.mode != conv_exc_pkg::MODE_REAL && cr0[18] && q.af && q.pl == 2'h3 && q.addr[2:0] != 3'h0)
      f = conv_exc_pkg::FLT_ALIGNMENT_CHECK;
    else if (q.cls != conv_exc_pkg::CLS_INT_TO_DBL && q.simd)
      f = cr4[10] ? conv_exc_pkg::FLT_VECTOR_FP : conv_exc_pkg::FLT_INVALID_OPCODE;
    return {f, vtab[f], f inside {[conv_exc_pkg::FLT_STACK:conv_exc_pkg::FLT_ALIGNMENT_CHECK]},
            f == conv_exc_pkg::FLT_PAGE_TRANSLATION ? q.pc : 32'h0};
  endfunction

  always @(negedge CLK_SYS) begin
    cyc++;
    if (cyc > 20000) begin
      n_errors++;
      stop_test();
    end else if (RSP_VALID === 1'b1)
      check({RSP_FAULT, RSP_VECTOR, RSP_ERR_VALID, RSP_ERR_CODE}, expq.size() ? expq.pop_front() : 'x);
  end

  initial begin
    NRST = 1'b0;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 12'h000;
    PWDATA = 32'h0;
    cr0 = 32'h0;
    cr4 = 32'h0;
    feat = 3'h7;
    lf = 16'h0;
    void'($urandom(79));
    repeat (3) @(posedge CLK_SYS);
    NRST <= 1'b1;
    apb(1'b1, 12'h00C, 32'hFFFF_FFFF);
    check(err, 1'b0);
    apb(1'b1, 12'h014, 32'hFFFF_FFFF);
    check(err, 1'b1);
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 12'(i * 4), 32'h0);
      check({err, rd}, {i == 5, i == 2 ? 32'h7 : 32'h0});
    end
    // The first batch runs with save/restore support still clear.
    for (int b = 0; b < 40; b++) begin
      if (b > 0) begin
        cr0 = $urandom & $urandom & 32'h0004_000C;
        cr4 = ($urandom & 32'h0000_0400) | (b % 8 == 7 ? 32'h0 : 32'h0000_0200);
        feat = b % 5 == 4 ? 3'($urandom) : 3'h7;
        apb(1'b1, 12'h000, cr0);
        apb(1'b1, 12'h004, cr4);
        apb(1'b1, 12'h008, {29'h0, feat});
        apb(1'b0, 12'h000, 32'h0);
        check({err, rd}, {1'b0, cr0});
      end
      apb(1'b1, 12'h010, 32'h0);
      nf = 0;
      repeat (16) begin
        r = rand_req();
        e = expect_of(r);
        expq.push_back(e);
        if (e[44:41] != 4'h0) begin
          nf++;
          lf = {e[40:33], 4'h0, e[44:41]};
        end
        decode_pipe_model_i.issue(r);
      end
      decode_pipe_model_i.idle();
      repeat (2) @(posedge CLK_SYS);
      apb(1'b0, 12'h010, 32'h0);
      check({err, rd}, {17'h0, 16'(nf)});
      apb(1'b0, 12'h00C, 32'h0);
      check({err, rd}, {17'h0, lf});
    end
    check(expq.size(), 0);
    stop_test();
  end
endmodule
